// ==== ddcp_drive_model.sv ====
// two daisy-chained drives; an unselected drive leaves the lines inactive
`timescale 1ns/1ps
module ddcp_drive_model #(parameter int REV = 600) (
  input wire logic i_clk,
  input wire logic [1:0] i_pick,
  input wire logic i_step,
  input wire logic i_step_inward,
  input wire logic i_bad_write,
  output logic o_seek_done,
  output logic o_outer_track_flag,
  output logic o_write_fault,
  output logic o_unit_ready,
  output logic o_index
);
  int cyl [2] = '{0, 0};
  int quiet = 99;
  int rev = 0;
  logic step_q = 1'b0;
  logic sel;
  assign sel = i_pick[1];
  always @(posedge i_clk) begin
    step_q <= i_step;
    rev <= (rev == REV - 1) ? 0 : rev + 1;
    // an unknown step before reset settles restarts the count instead of poisoning it
    quiet <= (i_step !== 1'b0) ? 0 : (quiet < 99 ? quiet + 1 : quiet);
    if (i_step && !step_q) begin
      cyl[sel] <= i_step_inward ? cyl[sel] + 1 : (cyl[sel] > 0 ? cyl[sel] - 1 : 0);
    end
  end
  // settle time is the model's own, longer than one step gap is not needed
  assign o_seek_done = |i_pick && quiet > 20;
  assign o_outer_track_flag = |i_pick && cyl[sel] == 0;
  assign o_write_fault = |i_pick && i_bad_write;
  assign o_unit_ready = |i_pick; // motor taken as up to speed
  assign o_index = |i_pick && rev < 4;
endmodule

// ==== ddcp_in_sync.sv ====
// two-flop synchronisers for the drive status inputs, index edge detect
`timescale 1ns/1ps
module ddcp_in_sync
  import ddcp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [4:0] i_raw,
  ddcp_sync_if.src o_sync
);
  typedef struct packed {
    logic [4:0] stage1;
    logic [4:0] stage2;
    logic idx_prev;
    logic idx_edge;
  } ddcp_sync_st_t;
  ddcp_sync_st_t st;
  ddcp_sync_st_t next_st;
  always_comb begin
    next_st = st;
    next_st.stage1 = i_raw;
    next_st.stage2 = st.stage1;
    next_st.idx_prev = st.stage2[4];
    next_st.idx_edge = st.stage2[4] & ~st.idx_prev;
  end
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign o_sync.seek_done = st.stage2[0];
  assign o_sync.outer_track_flag = st.stage2[1];
  assign o_sync.write_fault = st.stage2[2];
  assign o_sync.unit_ready = st.stage2[3];
  assign o_sync.index_pulse = st.idx_edge;
endmodule

// ==== ddcp_map.svh ====
// clock rate, timing counts and field widths for the drive control port
`ifndef DDCP_MAP_SVH
`define DDCP_MAP_SVH
`define DDCP_CLK_HZ 20000000
`define DDCP_STEP_PULSE_NS 8000
`define DDCP_STEP_PULSE_CYC ((`DDCP_STEP_PULSE_NS * 20 + 999) / 1000)
`define DDCP_SEL_SETTLE_CYC 16
`define DDCP_CYL_W 10
`define DDCP_HEAD_W 3
`define DDCP_IDX_CNT_W 8
`define DDCP_RWC_SCALE 2
`endif

// ==== ddcp_pkg.sv ====
// types shared by the drive control port modules
package ddcp_pkg;
  typedef enum logic [2:0] {
    DDCP_IDLE = 3'b000,
    DDCP_STEP_HI = 3'b001,
    DDCP_STEP_LO = 3'b010,
    DDCP_SETTLE = 3'b011,
    DDCP_WRITE = 3'b100
  } ddcp_state_t;
endpackage

// ==== ddcp_port.sv ====
// drive control port: select, head, step, direction and write gate logic
`timescale 1ns/1ps
`include "ddcp_map.svh"
// What this block does
// - one shared set of control outputs feeds both drives and the unit picks choose the drive.
// - shrink_write_drive follows, one cycle late, whether the present cylinder is at or above four times the threshold.
// - the head number goes out as a 3-bit binary code on three head pick lines.
// - write gate is on only while valid data is being written.
// - write gate drops as soon as the synchronised write fault from the selected drive appears.
// - write gate stays off through power up and reset.
// - seek done from the drive ends positioning.
// - index pulses give the format start point and count as the retry timeout.
// - the heads move to the target cylinder by step pulses with a set direction.
// - step_inward high moves heads in, low moves them out.
// - unit pick 0 selects the first drive and unit pick 1 the second.
module ddcp_port
  import ddcp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_unit,
  input wire logic [2:0] i_head,
  input wire logic [9:0] i_target_cyl,
  input wire logic i_seek_go,
  input wire logic i_recal_go,
  input wire logic [7:0] i_rwc_threshold,
  input wire logic i_write_req,
  input wire logic i_format_arm,
  input wire logic [7:0] i_retry_limit,
  input wire logic i_retry_start,
  input wire logic i_seek_done,
  input wire logic i_outer_track_flag,
  input wire logic i_write_fault,
  input wire logic i_unit_ready,
  input wire logic i_index,
  output logic o_unit_pick_0,
  output logic o_unit_pick_1,
  output logic o_head_pick_0,
  output logic o_head_pick_1,
  output logic o_head_pick_2,
  output logic o_step,
  output logic o_step_inward,
  output logic o_write_gate,
  output logic o_shrink_write_drive,
  output logic [9:0] o_present_cyl,
  output logic o_busy,
  output logic o_seek_ok,
  output logic o_fault,
  output logic o_ready,
  output logic o_outer_track,
  output logic o_format_start,
  output logic o_retry_timeout
);
  typedef struct packed {
    ddcp_state_t state;
    logic unit;
    logic [2:0] head;
    logic [9:0] cyl;
    logic [9:0] target;
    logic recal;
    logic step;
    logic inward;
    logic [7:0] tmr;
    logic wgate;
    logic seek_ok;
    logic fault;
    logic fmt_armed;
    logic fmt_start;
    logic [7:0] idx_cnt;
    logic retry_run;
    logic retry_to;
  } ddcp_port_st_t;

  ddcp_port_st_t st;
  ddcp_port_st_t next_st;
  ddcp_sync_if sync_bus ();
  logic rwc;

  ddcp_in_sync u_sync (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_raw({i_index, i_unit_ready, i_write_fault, i_outer_track_flag, i_seek_done}),
    .o_sync(sync_bus.src)
  );

  ddcp_rwc_cmp u_rwc (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_cyl(st.cyl),
    .i_threshold(i_rwc_threshold),
    .o_shrink(rwc)
  );

  function automatic logic [7:0] cyc8(input int n);
    cyc8 = (n > 255) ? 8'hFF : n[7:0];
  endfunction

  localparam logic [7:0] STEP_CYC = cyc8(`DDCP_STEP_PULSE_CYC);
  localparam logic [7:0] SETTLE_CYC = cyc8(`DDCP_SEL_SETTLE_CYC);

  always_comb begin
    next_st = st;
    next_st.fmt_start = 1'b0;
    case (st.state)
      DDCP_IDLE: begin
        // head and unit only follow the request while the port is idle, not during a seek or a write
        next_st.unit = i_unit;
        next_st.head = i_head;
        if (i_recal_go) begin
          next_st.recal = 1'b1;
          next_st.seek_ok = 1'b0;
          next_st.inward = 1'b0;
          next_st.state = DDCP_STEP_HI;
          next_st.tmr = STEP_CYC;
        end else if (i_seek_go) begin
          next_st.recal = 1'b0;
          next_st.target = i_target_cyl;
          next_st.seek_ok = 1'b0;
          if (i_target_cyl != st.cyl) begin
            next_st.inward = (i_target_cyl > st.cyl);
            next_st.state = DDCP_STEP_HI;
            next_st.tmr = STEP_CYC;
          end else begin
            next_st.state = DDCP_SETTLE;
            next_st.tmr = SETTLE_CYC;
          end
        end else if (i_write_req && sync_bus.unit_ready && !sync_bus.write_fault) begin
          next_st.fault = 1'b0;
          next_st.wgate = 1'b1;
          next_st.state = DDCP_WRITE;
        end
      end
      DDCP_STEP_HI: begin
        next_st.step = 1'b1;
        if (st.tmr == 8'h00) begin
          next_st.step = 1'b0;
          next_st.tmr = STEP_CYC;
          next_st.state = DDCP_STEP_LO;
          if (st.inward) begin
            next_st.cyl = st.cyl + 10'h001;
          end else if (st.cyl != 10'h000) begin
            next_st.cyl = st.cyl - 10'h001;
          end
        end else begin
          next_st.tmr = st.tmr - 8'h01;
        end
      end
      DDCP_STEP_LO: begin
        if (st.tmr != 8'h00) begin
          next_st.tmr = st.tmr - 8'h01;
        end else if (st.recal && sync_bus.outer_track_flag) begin
          next_st.cyl = 10'h000;
          next_st.state = DDCP_SETTLE;
          next_st.tmr = SETTLE_CYC;
        end else if (!st.recal && st.cyl == st.target) begin
          next_st.state = DDCP_SETTLE;
          next_st.tmr = SETTLE_CYC;
        end else begin
          next_st.state = DDCP_STEP_HI;
          next_st.tmr = STEP_CYC;
        end
      end
      DDCP_SETTLE: begin
        // wait out a short settle, then for the drive's own seek done
        if (st.tmr != 8'h00) begin
          next_st.tmr = st.tmr - 8'h01;
        end else if (sync_bus.seek_done) begin
          next_st.seek_ok = 1'b1;
          if (st.recal) begin
            next_st.cyl = 10'h000;
          end
          next_st.state = DDCP_IDLE;
        end
      end
      DDCP_WRITE: begin
        if (sync_bus.write_fault) begin
          next_st.wgate = 1'b0;
          next_st.fault = 1'b1;
          next_st.state = DDCP_IDLE;
        end else if (!i_write_req) begin
          next_st.wgate = 1'b0;
          next_st.state = DDCP_IDLE;
        end
      end
      default: begin
        next_st.state = DDCP_IDLE;
        next_st.wgate = 1'b0;
        next_st.step = 1'b0;
      end
    endcase
    // format start is the first index after arming
    if (i_format_arm) begin
      next_st.fmt_armed = 1'b1;
    end
    if ((st.fmt_armed || i_format_arm) && sync_bus.index_pulse) begin
      next_st.fmt_armed = 1'b0;
      next_st.fmt_start = 1'b1;
    end
    // retry timeout counts index pulses
    if (i_retry_start) begin
      next_st.retry_run = 1'b1;
      // a timeout landing on the restart cycle still shows, so it is never lost
      next_st.retry_to = st.retry_run && sync_bus.index_pulse &&
        (st.idx_cnt + 8'h01 >= i_retry_limit);
      next_st.idx_cnt = 8'h00;
    end else if (st.retry_run && sync_bus.index_pulse) begin
      next_st.idx_cnt = st.idx_cnt + 8'h01;
      if (st.idx_cnt + 8'h01 >= i_retry_limit) begin
        next_st.retry_run = 1'b0;
        next_st.retry_to = 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // the fault path is combinational so the gate drops in the same cycle
  // the synchronised fault appears, not one later
  assign o_write_gate = st.wgate & ~sync_bus.write_fault;
  assign o_unit_pick_0 = ~st.unit;
  assign o_unit_pick_1 = st.unit;
  assign o_head_pick_0 = st.head[0];
  assign o_head_pick_1 = st.head[1];
  assign o_head_pick_2 = st.head[2];
  assign o_step = st.step;
  assign o_step_inward = st.inward;
  assign o_shrink_write_drive = rwc;
  assign o_present_cyl = st.cyl;
  assign o_busy = (st.state != DDCP_IDLE);
  assign o_seek_ok = st.seek_ok;
  assign o_fault = st.fault;
  assign o_ready = sync_bus.unit_ready;
  assign o_outer_track = sync_bus.outer_track_flag;
  assign o_format_start = st.fmt_start;
  assign o_retry_timeout = st.retry_to;
endmodule

// ==== ddcp_port_properties.sv ====
// timing checks on the drive control port pins
`timescale 1ns/1ps
`include "ddcp_map.svh"
module ddcp_port_chk (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_write_req,
  input wire logic i_write_fault,
  input wire logic [7:0] i_rwc_threshold,
  input wire logic o_unit_pick_0,
  input wire logic o_unit_pick_1,
  input wire logic o_head_pick_0,
  input wire logic o_head_pick_1,
  input wire logic o_head_pick_2,
  input wire logic o_step,
  input wire logic o_step_inward,
  input wire logic o_write_gate,
  input wire logic o_shrink_write_drive,
  input wire logic [9:0] o_present_cyl,
  input wire logic o_busy,
  input wire logic o_ready
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  logic [8:0] hi_cnt;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) hi_cnt <= '0;
    else hi_cnt <= o_step ? hi_cnt + 9'h001 : '0;
  end
  // three samples cover the two-flop input synchroniser
  sequence fault_held; i_write_fault [*3]; endsequence
  sequence step_end; $fell(o_step); endsequence
  pick_onehot_a: assert property (o_unit_pick_0 != o_unit_pick_1)
    else $error("unit picks not one-hot");
  shrink_level_a: assert property ($past(i_nrst) |-> o_shrink_write_drive ==
    ($past(o_present_cyl) >= {$past(i_rwc_threshold), 2'h0}))
    else $error("shrink level wrong");
  gate_start_a: assert property ($rose(o_write_gate) |->
    $past(i_write_req) && $past(o_ready) && !$past(o_busy))
    else $error("gate rose without request");
  gate_end_a: assert property (o_write_gate && !i_write_req |=> !o_write_gate)
    else $error("gate outlived request");
  gate_fault_a: assert property (fault_held |-> !o_write_gate)
    else $error("gate on during fault");
  gate_powerup_a: assert property (!$past(i_nrst) |-> !o_write_gate)
    else $error("gate on after reset");
  write_freeze_a: assert property (o_write_gate && $past(o_write_gate) |-> !o_step &&
    $stable({o_head_pick_2, o_head_pick_1, o_head_pick_0}))
    else $error("step or head change in write");
  step_width_a: assert property (step_end |-> hi_cnt == 9'(`DDCP_STEP_PULSE_CYC))
    else $error("step pulse width wrong");
  dir_hold_a: assert property (o_step |-> $stable(o_step_inward))
    else $error("direction moved in step");
endmodule
bind ddcp_port ddcp_port_chk u_chk (.i_clk, .i_nrst, .i_write_req, .i_write_fault,
  .i_rwc_threshold, .o_unit_pick_0, .o_unit_pick_1, .o_head_pick_0, .o_head_pick_1,
  .o_head_pick_2, .o_step, .o_step_inward, .o_write_gate, .o_shrink_write_drive,
  .o_present_cyl, .o_busy, .o_ready);

// ==== ddcp_port_tb.sv ====
// self-checking bench for the drive control port
`timescale 1ns/1ps
module ddcp_port_tb;
  logic i_clk = 1'b0, i_nrst = 1'b0, i_unit = 1'b0, i_seek_go = 1'b0, i_recal_go = 1'b0;
  logic i_write_req = 1'b0, i_format_arm = 1'b0, i_retry_start = 1'b0, bad = 1'b0;
  logic [2:0] i_head = 3'h0;
  logic [9:0] i_target_cyl = 10'h000, o_present_cyl, steps;
  logic [7:0] i_rwc_threshold = 8'h01, i_retry_limit = 8'h02;
  logic i_seek_done, i_outer_track_flag, i_write_fault, i_unit_ready, i_index;
  logic o_unit_pick_0, o_unit_pick_1, o_head_pick_0, o_head_pick_1, o_head_pick_2;
  logic o_step, o_step_inward, o_write_gate, o_shrink_write_drive, o_busy, o_seek_ok;
  logic o_fault, o_ready, o_outer_track, o_format_start, o_retry_timeout;
  int n_errors = 0, checks = 0;
  ddcp_port dut (.*);
  ddcp_drive_model drv (.i_clk, .i_pick({o_unit_pick_1, o_unit_pick_0}), .i_step(o_step),
    .i_step_inward(o_step_inward), .i_bad_write(bad), .o_seek_done(i_seek_done),
    .o_outer_track_flag(i_outer_track_flag), .o_write_fault(i_write_fault),
    .o_unit_ready(i_unit_ready), .o_index(i_index));
  initial forever #25 i_clk = ~i_clk;
  always @(posedge o_step) steps <= steps + 10'h001;
  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  function automatic logic seen(input int k);
    case (k)
      0: return !o_busy;
      1: return o_format_start;
      default: return o_retry_timeout;
    endcase
  endfunction
  task automatic wait_on(input int k);
    int i;
    for (i = 0; i < 3000 && seen(k) !== 1'b1; i++) @(negedge i_clk);
    if (i == 3000) begin
      n_errors++;
      $display("ERROR %0t wait ran out", $time);
      report_and_stop();
    end
  endtask
  task automatic t_select();
    for (int h = 0; h < 8; h++) begin
      i_unit = h[0];
      i_head = h[2:0];
      repeat (3) @(negedge i_clk);
      chk({5'h00, o_unit_pick_1, o_unit_pick_0, o_head_pick_2, o_head_pick_1, o_head_pick_0},
        {5'h00, h[0], !h[0], h[2:0]});
    end
    i_unit = 1'b0;
    repeat (3) @(negedge i_clk);
  endtask
  task automatic t_seek(input logic [9:0] tgt, input logic dir, input logic [9:0] n,
    input logic shr);
    steps = 10'h000;
    i_target_cyl = tgt;
    i_seek_go = 1'b1;
    @(negedge i_clk);
    i_seek_go = 1'b0;
    chk({9'h000, o_step_inward}, {9'h000, dir});
    wait_on(0);
    chk(o_present_cyl, tgt);
    chk(steps, n);
    chk({8'h00, o_seek_ok, o_shrink_write_drive}, {8'h00, 1'b1, shr});
  endtask
  task automatic t_recal();
    i_recal_go = 1'b1;
    @(negedge i_clk);
    i_recal_go = 1'b0;
    chk({9'h000, o_step_inward}, 10'h000);
    wait_on(0);
    repeat (3) @(negedge i_clk);
    chk({o_present_cyl[8:0], o_outer_track}, 10'h001);
  endtask
  task automatic t_write();
    i_write_req = 1'b1;
    repeat (2) @(negedge i_clk);
    chk({9'h000, o_write_gate}, 10'h001);
    chk({9'h000, o_ready}, 10'h001);
    i_seek_go = 1'b1;
    i_head = 3'h5;
    @(negedge i_clk);
    i_seek_go = 1'b0;
    repeat (6) @(negedge i_clk);
    chk({6'h00, o_step, o_head_pick_2, o_head_pick_1, o_head_pick_0}, 10'h007);
    bad = 1'b1;
    repeat (4) @(negedge i_clk);
    chk({8'h00, o_write_gate, o_fault}, 10'h001);
    i_write_req = 1'b0;
    @(negedge i_clk);
    bad = 1'b0;
    repeat (4) @(negedge i_clk);
    i_write_req = 1'b1;
    repeat (2) @(negedge i_clk);
    chk({8'h00, o_write_gate, o_fault}, 10'h002);
    i_write_req = 1'b0;
    repeat (2) @(negedge i_clk);
    chk({9'h000, o_write_gate}, 10'h000);
  endtask
  task automatic t_reset();
    i_write_req = 1'b1;
    repeat (4) @(negedge i_clk);
    i_nrst = 1'b0;
    @(negedge i_clk);
    chk({8'h00, o_write_gate, o_unit_pick_0}, 10'h001);
    repeat (2) @(negedge i_clk);
    i_write_req = 1'b0;
    i_nrst = 1'b1;
    repeat (4) @(negedge i_clk);
  endtask
  task automatic t_index();
    i_format_arm = 1'b1;
    @(negedge i_clk);
    i_format_arm = 1'b0;
    wait_on(1);
    i_retry_start = 1'b1;
    @(negedge i_clk);
    i_retry_start = 1'b0;
    chk({9'h000, o_retry_timeout}, 10'h000);
    wait_on(2);
  endtask
  initial begin
    repeat (5) @(negedge i_clk);
    chk({7'h00, o_write_gate, o_step, o_unit_pick_0}, 10'h001);
    repeat (15) @(negedge i_clk);
    i_nrst = 1'b1;
    repeat (4) @(negedge i_clk);
    t_select();
    t_seek(10'h004, 1'b1, 10'h004, 1'b1);
    t_seek(10'h001, 1'b0, 10'h003, 1'b0);
    t_recal();
    t_write();
    t_reset();
    t_index();
    report_and_stop();
  end
endmodule

// ==== ddcp_rwc_cmp.sv ====
// reduce-write-current threshold compare
`timescale 1ns/1ps
module ddcp_rwc_cmp
  import ddcp_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic [9:0] i_cyl,
  input wire logic [7:0] i_threshold,
  output logic o_shrink
);
  typedef struct packed {
    logic shrink;
  } ddcp_rwc_st_t;
  ddcp_rwc_st_t st;
  ddcp_rwc_st_t next_st;
  always_comb begin
    next_st = st;
    // threshold is programmed in units of four cylinders
    next_st.shrink = (i_cyl >= {i_threshold, 2'b00});
  end
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign o_shrink = st.shrink;
endmodule

// ==== ddcp_sync_if.sv ====
// synchronised drive status lines carried from the input stage
`timescale 1ns/1ps
interface ddcp_sync_if;
  logic seek_done;
  logic outer_track_flag;
  logic write_fault;
  logic unit_ready;
  logic index_pulse;
  modport src (output seek_done, output outer_track_flag, output write_fault,
    output unit_ready, output index_pulse);
  modport dst (input seek_done, input outer_track_flag, input write_fault,
    input unit_ready, input index_pulse);
endinterface
